// *** rws_sequencer.v ***
// Purpose: clock start-up, reset merging, watchdog and stop-mode sequencer
// Assumes: one 250 MHz clock; supply, pin and wake inputs are asynchronous
// Notes: control bits are plain ports; no register bus
// Notes on behaviour
// - Gate clock until supply good, then 1000 cycles
// - Power-on resets all, sets power-on flag
// - Fetch from 8000h after any reset
// - Brownout resets at once, start-up wait after
// - Brownout during start-up returns to brownout
// - Start in brownout; detection stays active
// - Brownout reset equals power-on reset
// - Two-bit select picks four watchdog timeouts
// - Interrupt at timeout, reset 512 cycles later
// - Watchdog reset pulse lasts four cycles
// - Watchdog reset sets watchdog reset flag
// - Low reset pin holds reset; resume at start
// - Bootload command BBh at 34h resets device
// - Programming done with reset-on-done resets
// - Stop bit gates core clock, disables ADC
// - Only enabled wake sources, pin or brownout exit stop
// - Back in CPU mode within ten cycles
// - Interrupt wake continues; reset wake restarts
`timescale 1ns/1ps
`include "rws_defs.vh"
module rws_sequencer #(
  parameter STARTUP_CYCLES = `RWS_STARTUP_CYCLES,
  parameter WD_GRACE = `RWS_WD_GRACE,
  parameter WD_PULSE = `RWS_WD_PULSE,
  parameter WAKE_CYCLES = `RWS_WAKE_CYCLES,
  parameter WD_SHIFT = 0
) (
  input wire mclk_i,
  input wire rst_i,
  input wire supply_good_i,
  input wire ext_reset_n_i,
  input wire port6_irq_i,
  input wire port6_irq_en_i,
  input wire i2c_start_irq_i,
  input wire i2c_start_irq_en_i,
  input wire svm_irq_i,
  input wire svm_irq_en_i,
  input wire boot_mode_i,
  input wire boot_cmd_valid_i,
  input wire [6:0] boot_addr_i,
  input wire [7:0] boot_cmd_i,
  input wire prog_done_i,
  input wire reset_on_program_done_i,
  input wire stop_request_bit_i,
  input wire [1:0] watchdog_interval_select_i,
  input wire watchdog_enable_i,
  input wire watchdog_reset_enable_i,
  input wire watchdog_restart_i,
  input wire por_flag_clear_i,
  input wire watchdog_reset_flag_clear_i,
  output reg instruction_clock_en_o,
  output reg core_reset_o,
  output reg [15:0] fetch_addr_o,
  output reg fetch_addr_load_o,
  output reg stop_mode_o,
  output reg adc_enable_o,
  output reg watchdog_irq_o,
  output reg [7:0] watchdog_control_reg_o,
  output reg [2:0] seq_state_o
);
  localparam ST_BROWN = `RWS_ST_BROWN;
  localparam ST_START = `RWS_ST_START;
  localparam ST_CPU = `RWS_ST_CPU;
  localparam ST_STOP = `RWS_ST_STOP;
  localparam ST_WAKE = `RWS_ST_WAKE;

  wire supply_s;
  wire ext_n_s;
  wire p6_s;
  wire i2c_s;
  wire svm_s;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [9:0] start_cnt;
  reg [3:0] wake_cnt;
  reg [21:0] wd_cnt;
  reg [9:0] grace_cnt;
  reg wd_armed;
  reg [2:0] pulse_cnt;
  reg wd_pulse;
  reg wd_fire;
  reg por_flag;
  reg watchdog_reset_flag;
  reg ext_rst_d;
  reg boot_hit;
  reg rod_hit;
  wire wake_irq;
  wire wd_timeout;
  wire warm_src;

  // Timeout compare point for a select code
  function [21:0] wd_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: wd_limit = (22'h000001 << (`RWS_WD_EXP0 - WD_SHIFT)) - 22'h000001;
        2'h1: wd_limit = (22'h000001 << (`RWS_WD_EXP1 - WD_SHIFT)) - 22'h000001;
        2'h2: wd_limit = (22'h000001 << (`RWS_WD_EXP2 - WD_SHIFT)) - 22'h000001;
        default: wd_limit = (22'h000001 << (`RWS_WD_EXP3 - WD_SHIFT)) - 22'h000001;
      endcase
    end
  endfunction

  // Synchronise asynchronous levels
  rws_sync #(.W(5), .INIT(5'h02)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i({supply_good_i, ext_reset_n_i, port6_irq_i, i2c_start_irq_i, svm_irq_i}),
    .q_o({supply_s, ext_n_s, p6_s, i2c_s, svm_s})
  );

  // Only enabled sources may wake from stop
  assign wake_irq = (p6_s & port6_irq_en_i) | (i2c_s & i2c_start_irq_en_i) |
                    (svm_s & svm_irq_en_i);
  assign wd_timeout = (wd_cnt == wd_limit(watchdog_interval_select_i));
  assign warm_src = ~ext_n_s | wd_pulse | boot_hit | rod_hit;

  // Sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_BROWN: begin
        if (supply_s) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (!supply_s) begin
          next_state = ST_BROWN;
        end else if (start_cnt == STARTUP_CYCLES - 1) begin
          next_state = ST_CPU;
        end
      end
      ST_CPU: begin
        if (!supply_s) begin
          next_state = ST_BROWN;
        end else if (stop_request_bit_i && !warm_src) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!supply_s) begin
          next_state = ST_BROWN;
        end else if (!ext_n_s || wake_irq) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!supply_s) begin
          next_state = ST_BROWN;
        end else if (wake_cnt == WAKE_CYCLES - 1) begin
          next_state = ST_CPU;
        end
      end
      default: next_state = ST_BROWN;
    endcase
  end

  // State register and start-up and wake counters
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_BROWN;
      start_cnt <= 10'h000;
      wake_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state == ST_START && next_state == ST_START) begin
        start_cnt <= start_cnt + 10'h001;
      end else begin
        start_cnt <= 10'h000;
      end
      if (state == ST_WAKE && next_state == ST_WAKE) begin
        wake_cnt <= wake_cnt + 4'h1;
      end else begin
        wake_cnt <= 4'h0;
      end
    end
  end

  // Bootload and programming-done reset requests, one cycle each
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_hit <= 1'b0;
      rod_hit <= 1'b0;
    end else begin
      boot_hit <= boot_mode_i && boot_cmd_valid_i && boot_addr_i == `RWS_BOOT_ADDR &&
                  boot_cmd_i == `RWS_BOOT_CMD;
      rod_hit <= prog_done_i && reset_on_program_done_i;
    end
  end

  // Watchdog counter, early interrupt, grace period and reset pulse
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_cnt <= 22'h000000;
      grace_cnt <= 10'h000;
      wd_armed <= 1'b0;
      watchdog_irq_o <= 1'b0;
      pulse_cnt <= 3'h0;
      wd_pulse <= 1'b0;
      wd_fire <= 1'b0;
    end else begin
      wd_fire <= 1'b0;
      if (wd_pulse) begin
        if (pulse_cnt == WD_PULSE - 1) begin
          wd_pulse <= 1'b0;
          pulse_cnt <= 3'h0;
        end else begin
          pulse_cnt <= pulse_cnt + 3'h1;
        end
      end
      if (state != ST_CPU || core_reset_o || watchdog_restart_i || !watchdog_enable_i) begin
        // Restart clears the timer and the pending reset
        wd_cnt <= 22'h000000;
        grace_cnt <= 10'h000;
        wd_armed <= 1'b0;
        if (watchdog_restart_i || core_reset_o) begin
          watchdog_irq_o <= 1'b0;
        end
      end else if (wd_armed) begin
        if (grace_cnt == WD_GRACE - 1) begin
          wd_armed <= 1'b0;
          grace_cnt <= 10'h000;
          wd_cnt <= 22'h000000;
          if (watchdog_reset_enable_i) begin
            wd_pulse <= 1'b1;
            wd_fire <= 1'b1;
          end
        end else begin
          grace_cnt <= grace_cnt + 10'h001;
        end
      end else if (wd_timeout) begin
        wd_armed <= 1'b1;
        watchdog_irq_o <= 1'b1;
      end else begin
        wd_cnt <= wd_cnt + 22'h000001;
      end
    end
  end

  // Status flags; power-on covers brownout, set wins over clear
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      por_flag <= 1'b1;
      watchdog_reset_flag <= 1'b0;
    end else if (state == ST_BROWN) begin
      por_flag <= 1'b1;
      watchdog_reset_flag <= 1'b0;
    end else begin
      if (por_flag_clear_i) begin
        por_flag <= 1'b0;
      end
      if (wd_fire) begin
        watchdog_reset_flag <= 1'b1;
      end else if (watchdog_reset_flag_clear_i) begin
        watchdog_reset_flag <= 1'b0;
      end
    end
  end

  // Merged synchronous core reset and outputs
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      instruction_clock_en_o <= 1'b0;
      stop_mode_o <= 1'b0;
      adc_enable_o <= 1'b0;
      fetch_addr_o <= `RWS_RESET_ADDR;
      fetch_addr_load_o <= 1'b0;
      ext_rst_d <= 1'b0;
      watchdog_control_reg_o <= 8'h00;
      seq_state_o <= ST_BROWN;
    end else begin
      core_reset_o <= (next_state == ST_BROWN) || (next_state == ST_START) ||
                      warm_src;
      instruction_clock_en_o <= (next_state == ST_CPU) || (next_state == ST_WAKE &&
                                wake_cnt == WAKE_CYCLES - 1);
      stop_mode_o <= (next_state == ST_STOP) || (next_state == ST_WAKE);
      adc_enable_o <= (next_state == ST_CPU);
      ext_rst_d <= (state == ST_STOP || state == ST_WAKE) ? ~ext_n_s : 1'b0;
      // Address reload on reset release; interrupt wake keeps core position
      fetch_addr_o <= `RWS_RESET_ADDR;
      fetch_addr_load_o <= core_reset_o && !(next_state == ST_BROWN ||
                           next_state == ST_START || warm_src);
      watchdog_control_reg_o <= 8'h00;
      watchdog_control_reg_o[`RWS_WDC_POR_BIT] <= por_flag;
      watchdog_control_reg_o[`RWS_WDC_SEL_HI:`RWS_WDC_SEL_LO] <= watchdog_interval_select_i;
      watchdog_control_reg_o[`RWS_WDC_WATCHDOG_RESET_FLAG_BIT] <= watchdog_reset_flag;
      seq_state_o <= next_state;
    end
  end
endmodule // rws_sequencer

// *** rws_defs.vh ***
// Purpose: constants for the reset, watchdog and stop sequencer
// Assumes: 250 MHz mclk_i, one system clock period is one mclk_i cycle
// Notes: definitions only
`ifndef RWS_DEFS_VH
`define RWS_DEFS_VH

// Oscillator start-up interval in cycles
`define RWS_STARTUP_CYCLES 1000
// Reset start address
`define RWS_RESET_ADDR 16'h8000
// Watchdog control register fields
`define RWS_WDC_POR_BIT 7
`define RWS_WDC_WATCHDOG_RESET_FLAG_BIT 2
`define RWS_WDC_SEL_HI 5
`define RWS_WDC_SEL_LO 4
// Watchdog timeout exponents for select codes 0..3
`define RWS_WD_EXP0 12
`define RWS_WD_EXP1 15
`define RWS_WD_EXP2 18
`define RWS_WD_EXP3 21
// Interrupt to reset delay and reset pulse length
`define RWS_WD_GRACE 512
`define RWS_WD_PULSE 4
// Wake-up latency budget and the delay actually used
`define RWS_WAKE_MAX 10
`define RWS_WAKE_CYCLES 4
// I2C bootload reset command
`define RWS_BOOT_ADDR 7'h34
`define RWS_BOOT_CMD 8'hBB
// Sequencer states
`define RWS_ST_BROWN 3'h0
`define RWS_ST_START 3'h1
`define RWS_ST_CPU 3'h2
`define RWS_ST_STOP 3'h3
`define RWS_ST_WAKE 3'h4

`endif

// *** rws_sync.v ***
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: single clock domain mclk_i
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module rws_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta;

  // Two-stage capture
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= INIT;
      q_o <= INIT;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule // rws_sync

// *** rws_far_side.sv ***
// Purpose: far side model: supply monitor, reset pin, wake sources
// Assumes: levels change 1 ns after a rising edge
// Notes: every line is always driven, none floats
`timescale 1ns/1ps
module rws_far_side (
  input wire mclk_i,
  output reg supply_o,
  output reg pin_n_o,
  output reg [2:0] irq_o
);
  // Powered down, pin released, sources quiet
  initial begin
    supply_o = 1'b0;
    pin_n_o = 1'b1;
    irq_o = 3'h0;
  end
  // Move all levels together just after an edge
  task put(input s, input p, input [2:0] q);
    begin
      @(posedge mclk_i);
      #1;
      supply_o = s;
      pin_n_o = p;
      irq_o = q;
    end
  endtask
endmodule // rws_far_side

// *** rws_seq_monitor.sv ***
// Purpose: port checks on the sequencer
// Assumes: one clock, rst_i asynchronous active high
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module rws_seq_chk (
  input wire mclk_i,
  input wire rst_i,
  input wire supply_good_i,
  input wire ext_reset_n_i,
  input wire port6_irq_i,
  input wire port6_irq_en_i,
  input wire i2c_start_irq_i,
  input wire i2c_start_irq_en_i,
  input wire svm_irq_i,
  input wire svm_irq_en_i,
  input wire instruction_clock_en_o,
  input wire core_reset_o,
  input wire [15:0] fetch_addr_o,
  input wire fetch_addr_load_o,
  input wire stop_mode_o,
  input wire adc_enable_o,
  input wire [7:0] watchdog_control_reg_o,
  input wire [2:0] seq_state_o
);
  // Enabled wake request and a quiet stop
  wire wake = (port6_irq_i & port6_irq_en_i) | (i2c_start_irq_i & i2c_start_irq_en_i)
    | (svm_irq_i & svm_irq_en_i);
  wire quiet = supply_good_i & ext_reset_n_i & ~wake;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_brown_hold: assert property (
    (seq_state_o == 3'h0) [*3]
    |-> core_reset_o && !instruction_clock_en_o && watchdog_control_reg_o[7])
    else $error("brownout hold wrong");
  a_brown_enter: assert property (
    $fell(supply_good_i) |-> ##[1:4] (core_reset_o && seq_state_o == 3'h0))
    else $error("brownout entry late");
  a_start_abort: assert property (
    seq_state_o == 3'h1 && !supply_good_i |-> ##[1:4] seq_state_o == 3'h0)
    else $error("start-up not aborted");
  a_load_addr: assert property (
    fetch_addr_load_o |-> fetch_addr_o == 16'h8000 && !core_reset_o)
    else $error("bad start address");
  a_release_load: assert property (
    $fell(core_reset_o) |-> fetch_addr_load_o)
    else $error("release without load");
  a_stop_quiet: assert property (
    stop_mode_o |-> !adc_enable_o && !instruction_clock_en_o)
    else $error("core active in stop");
  a_stop_hold: assert property (
    (seq_state_o == 3'h3 && quiet) [*4] |=> seq_state_o == 3'h3)
    else $error("stop left without cause");
  a_wake_time: assert property (
    seq_state_o == 3'h3 && wake && supply_good_i |-> ##[1:10] seq_state_o == 3'h2)
    else $error("wake too slow");
endmodule // rws_seq_chk
bind rws_sequencer rws_seq_chk u_chk (.mclk_i, .rst_i, .supply_good_i, .ext_reset_n_i,
  .port6_irq_i, .port6_irq_en_i, .i2c_start_irq_i, .i2c_start_irq_en_i, .svm_irq_i,
  .svm_irq_en_i, .instruction_clock_en_o, .core_reset_o, .fetch_addr_o,
  .fetch_addr_load_o, .stop_mode_o, .adc_enable_o, .watchdog_control_reg_o, .seq_state_o);

// *** tb_top.sv ***
// Purpose: self-checking bench for the sequencer
// Assumes: start-up 20 cycles, watchdog exponents less 9
// Notes: far side model drives supply, pin and wake levels
`timescale 1ns/1ps
module tb_top;
  localparam SU = 20;
  reg mclk_i = 0, rst_i = 1, port6_irq_en_i = 0, i2c_start_irq_en_i = 0, svm_irq_en_i = 0;
  reg boot_mode_i = 0, boot_cmd_valid_i = 0, prog_done_i = 0, reset_on_program_done_i = 0;
  reg stop_request_bit_i = 0, watchdog_enable_i = 0, watchdog_reset_enable_i = 0;
  reg watchdog_restart_i = 0, por_flag_clear_i = 0, watchdog_reset_flag_clear_i = 0;
  reg [6:0] boot_addr_i = 7'h34;
  reg [7:0] boot_cmd_i = 8'h00;
  reg [1:0] watchdog_interval_select_i = 2'h0;
  wire supply_good_i, ext_reset_n_i, port6_irq_i, i2c_start_irq_i, svm_irq_i, stop_mode_o;
  wire instruction_clock_en_o, core_reset_o, fetch_addr_load_o, adc_enable_o, watchdog_irq_o;
  wire [15:0] fetch_addr_o;
  wire [7:0] watchdog_control_reg_o;
  wire [2:0] seq_state_o;
  integer error_cnt = 0, checked = 0, n, i, s, sn;
  integer wq[$];
  rws_sequencer #(.STARTUP_CYCLES(SU), .WD_SHIFT(9)) u_dut (.*);
  rws_far_side u_far (.mclk_i, .supply_o(supply_good_i), .pin_n_o(ext_reset_n_i),
    .irq_o({port6_irq_i, i2c_start_irq_i, svm_irq_i}));
  // Clock and hang guard
  initial forever #2 mclk_i = ~mclk_i;
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  // Step to just past an edge
  task tk(input integer c);
    begin
      repeat (c) @(posedge mclk_i);
      #1;
    end
  endtask
  // Compare a design value
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  // Compare a cycle count with a window
  task chkn(input integer lo, input integer hi);
    begin
      checked = checked + 1;
      if (n < lo || n > hi) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: took %0d cycles", $time, n);
      end
    end
  endtask
  // Count cycles until a chosen output condition
  task cyc(input [1:0] k);
    begin
      n = 0;
      while (n < 9000 && !(k == 0 ? core_reset_o === 1'b0 : k == 1 ? core_reset_o === 1'b1
          : k == 2 ? watchdog_irq_o === 1'b1 : seq_state_o === 3'h2)) begin
        tk(1);
        n = n + 1;
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Power-up, brownouts, watchdog, stop and internal resets
  initial begin
    s = $urandom(85024);
    tk(5);
    rst_i = 0;
    u_far.put(1, 1, 3'h0);
    cyc(0);
    chkn(SU + 1, SU + 5);
    chk(fetch_addr_load_o, 1);
    chk(fetch_addr_o, 16'h8000);
    chk(instruction_clock_en_o, 1);
    por_flag_clear_i = 1;
    tk(1);
    por_flag_clear_i = 0;
    u_far.put(0, 1, 3'h0);
    tk(4);
    chk(core_reset_o, 1);
    u_far.put(1, 1, 3'h0);
    tk(SU / 2);
    u_far.put(0, 1, 3'h0);
    tk(4);
    u_far.put(1, 1, 3'h0);
    cyc(0);
    chkn(SU + 1, SU + 5);
    chk(watchdog_control_reg_o[7], 1);
    s = $urandom % 4;
    watchdog_enable_i = 1;
    for (i = 0; i < 5; i = i + 1) begin
      wq.push_back((s + i) % 4);
      watchdog_interval_select_i = wq[i];
      watchdog_reset_enable_i = i == 4;
      watchdog_restart_i = 1;
      tk(1);
      watchdog_restart_i = 0;
      cyc(2);
      sn = 1 << (3 * wq[i] + 3);
      chkn(sn - 3, sn + 3);
    end
    cyc(1);
    chkn(509, 515);
    cyc(0);
    watchdog_enable_i = 0;
    chkn(4, 6);
    chk(watchdog_control_reg_o[2], 1);
    for (i = 0; i < 4; i = i + 1) begin
      stop_request_bit_i = 1;
      tk(2);
      stop_request_bit_i = 0;
      chk({stop_mode_o, adc_enable_o, instruction_clock_en_o}, 3'h4);
      u_far.put(1, i < 3, 3'h1 << i);
      if (i == 3) begin
        cyc(3);
        chkn(1, 10);
      end
      tk(8);
      chk(core_reset_o, i == 3);
      {port6_irq_en_i, i2c_start_irq_en_i, svm_irq_en_i} = 3'h1 << i;
      if (i == 3)
        u_far.put(1, 1, 3'h0);
      if (i < 3) begin
        cyc(3);
        chkn(1, 10);
      end
      cyc(0);
      chk(fetch_addr_load_o, i == 3);
      {port6_irq_en_i, i2c_start_irq_en_i, svm_irq_en_i} = 3'h0;
      u_far.put(1, 1, 3'h0);
    end
    for (i = 0; i < 6; i = i + 1) begin
      boot_mode_i = i != 1;
      boot_addr_i = i == 2 ? 7'h35 : 7'h34;
      boot_cmd_i = i == 0 ? $urandom % 8'hBB : 8'hBB;
      reset_on_program_done_i = i == 5;
      boot_cmd_valid_i = i < 4;
      prog_done_i = i > 3;
      tk(1);
      boot_cmd_valid_i = 0;
      prog_done_i = 0;
      sn = 0;
      repeat (6) begin
        tk(1);
        sn = sn | core_reset_o;
      end
      chk(sn, i == 3 || i == 5);
      cyc(0);
    end
    print_verdict;
  end
endmodule // tb_top
